/* File: fbph_pkg.sv */
// Package for the four-bit port: register offsets, field widths, reset values.
// Assumes a plain address/strobe register port with 8-bit data.
package fbph_pkg;
    localparam int          FBPH_ADDR_W          = 4;
    localparam int          FBPH_DATA_W          = 8;
    localparam int          FBPH_PINS            = 4;
    localparam logic [3:0]  FBPH_OFS_DIRECTION   = 4'h0;
    localparam logic [3:0]  FBPH_OFS_OUT_LATCH   = 4'h1;
    localparam logic [3:0]  FBPH_OFS_LEVEL_VIEW  = 4'h2;
    localparam logic [3:0]  FBPH_OFS_CONTROL     = 4'h3;
    localparam logic [3:0]  FBPH_RST_DIRECTION   = 4'h0;
    localparam logic [3:0]  FBPH_RST_OUT_LATCH   = 4'h0;
    localparam logic [6:0]  FBPH_RST_CONTROL     = 7'h00;
    localparam logic [3:0]  FBPH_RSVD_FILL       = 4'h0;
    localparam logic [7:0]  FBPH_UNMAPPED_READ   = 8'h00;
    // Control register fields
    localparam int          FBPH_CTL_EXPANSION_ENABLE        = 0;
    localparam int          FBPH_CTL_OEE         = 1;
    localparam int          FBPH_CTL_OES         = 2;
    localparam int          FBPH_CTL_CS_LO       = 3;
    // Chip-select enables: bit CS_LO + n serves pin n, pin 3 included
    localparam int          FBPH_CTL_W           = 7;
    // Operating modes without built-in expansion, and the pin that carries the strobe
    localparam logic [2:0]  FBPH_MODE_SINGLE_A   = 3'h3;
    localparam logic [2:0]  FBPH_MODE_SINGLE_B   = 3'h7;
    localparam int          FBPH_PIN_STROBE      = 3;
endpackage

/* File: fbph_port.sv */
// Four-bit general purpose port with shared strobe and chip-select outputs.
// Assumes synchronous pin inputs, one clock, and a one-cycle-latency register port.
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`default_nettype none

// Function
// R1: Direction register is write only
// R2: Reserved upper bits read undefined
// R3: Per-pin direction bits, reset 0, 1=output
// R4: Expanded, strobe enable and select drive pin3
// R5: Else pin3 chip select if direction set
// R6: Pin3 general I/O when select cleared
// R7: Pins2..0 chip select when enabled, direction set
// R8: Pins2..0 general I/O when selects cleared
// R9: Modes 3,7 without expansion: general I/O
// R10: Output latch readable, reset 0, drives outputs
// R11: Output latch upper bits read zero
// R12: Level view: latch if output, pin if input
// R13: Level view read only
module fbph_port
    import fbph_pkg::*;
(
    input  wire logic                   ref_clk_in,
    input  wire logic                   rst_in,
    input  wire logic [FBPH_ADDR_W-1:0] addr_in,
    input  wire logic [FBPH_DATA_W-1:0] wdata_in,
    input  wire logic                   wr_in,
    input  wire logic                   rd_in,
    output logic      [FBPH_DATA_W-1:0] rdata_out,
    input  wire logic [2:0]             mode_in,
    input  wire logic                   oe_strobe_in,
    input  wire logic [FBPH_PINS-1:0]   chip_select_in,
    input  wire logic [FBPH_PINS-1:0]   pin_in,
    output logic      [FBPH_PINS-1:0]   pin_out,
    output logic      [FBPH_PINS-1:0]   pin_oe_n_out
);
    if (FBPH_DATA_W != 8 || FBPH_PINS != 4 || FBPH_CTL_W != 7) begin : g_bad_size
        $error("fbph_port serves only an 8-bit register, four-pin port");
    end

    logic [FBPH_PINS-1:0]  pin_direction;
    logic [FBPH_PINS-1:0]  output_latch;
    logic [FBPH_CTL_W-1:0] control;
    logic                  bus_mode;
    logic                  strobe_sel;
    logic [FBPH_PINS-1:0]  cs_sel;
    logic [FBPH_PINS-1:0]  pin_level_view;
    logic [FBPH_DATA_W-1:0] next_rdata;

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            pin_direction <= FBPH_RST_DIRECTION; // R3
        end else if (wr_in && addr_in == FBPH_OFS_DIRECTION) begin
            pin_direction <= wdata_in[FBPH_PINS-1:0]; // R3
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            output_latch <= FBPH_RST_OUT_LATCH; // R10
        end else if (wr_in && addr_in == FBPH_OFS_OUT_LATCH) begin
            output_latch <= wdata_in[FBPH_PINS-1:0]; // R11
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            control <= FBPH_RST_CONTROL;
        end else if (wr_in && addr_in == FBPH_OFS_CONTROL) begin
            control <= wdata_in[FBPH_CTL_W-1:0];
        end
    end

    // Modes 3 and 7 need the expansion bit before any bus function appears
    assign bus_mode = ((mode_in != FBPH_MODE_SINGLE_A) && (mode_in != FBPH_MODE_SINGLE_B))
                      || control[FBPH_CTL_EXPANSION_ENABLE]; // R9
    assign strobe_sel = bus_mode && control[FBPH_CTL_OEE] && control[FBPH_CTL_OES]; // R4

    genvar g;
    generate
        for (g = 0; g < FBPH_PINS; g++) begin : g_pin
            logic cs_en;
            logic strobe_here;
            assign cs_en = bus_mode && control[FBPH_CTL_CS_LO + g]; // R7
            assign strobe_here = (g == FBPH_PIN_STROBE) && strobe_sel; // R4
            assign cs_sel[g] = !strobe_here && cs_en && pin_direction[g]; // R5 R7
            always_comb begin
                if (strobe_here) begin
                    pin_out[g]      = oe_strobe_in; // R4
                    pin_oe_n_out[g] = 1'b0;
                end else if (cs_sel[g]) begin
                    pin_out[g]      = chip_select_in[g]; // R5 R7
                    pin_oe_n_out[g] = 1'b0;
                end else begin
                    // Chip-select enabled with direction 0 falls to input here
                    pin_out[g]      = output_latch[g]; // R6 R8 R10
                    pin_oe_n_out[g] = !pin_direction[g]; // R3
                end
            end
            assign pin_level_view[g] = pin_direction[g] ? output_latch[g] : pin_in[g]; // R12
        end
    endgenerate

    // Undefined reads are given zeros so the model stays deterministic
    always_comb begin
        next_rdata = FBPH_UNMAPPED_READ;
        case (addr_in)
            FBPH_OFS_DIRECTION:  next_rdata = FBPH_UNMAPPED_READ; // R1 R2
            FBPH_OFS_OUT_LATCH:  next_rdata = {FBPH_RSVD_FILL, output_latch}; // R10 R11
            FBPH_OFS_LEVEL_VIEW: next_rdata = {FBPH_RSVD_FILL, pin_level_view}; // R2 R12 R13
            FBPH_OFS_CONTROL:    next_rdata = {1'b0, control};
            default:             next_rdata = FBPH_UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            rdata_out <= FBPH_UNMAPPED_READ;
        end else if (rd_in) begin
            rdata_out <= next_rdata;
        end else begin
            rdata_out <= FBPH_UNMAPPED_READ;
        end
    end

    // Reset checks run without disable so the edge after release is seen
    a_dir_reset: assert property ( // R3
        @(posedge ref_clk_in)
        $fell(rst_in)
        |-> pin_oe_n_out == 4'hF
    ) else $error("Pins not input after reset");

    a_latch_reset: assert property ( // R10
        @(posedge ref_clk_in)
        $fell(rst_in)
        |-> output_latch == FBPH_RST_OUT_LATCH
    ) else $error("Latch not cleared by reset");

    a_dir_write_only: assert property ( // R1
        @(posedge ref_clk_in) disable iff (rst_in)
        rd_in && addr_in == FBPH_OFS_DIRECTION
        |=> rdata_out == FBPH_UNMAPPED_READ
    ) else $error("Direction register read back");

    a_dir_upper: assert property ( // R2
        @(posedge ref_clk_in) disable iff (rst_in)
        rd_in && addr_in == FBPH_OFS_DIRECTION
        |=> rdata_out[7:4] == FBPH_RSVD_FILL
    ) else $error("Direction upper bits not filled");

    a_view_upper: assert property ( // R2
        @(posedge ref_clk_in) disable iff (rst_in)
        rd_in && addr_in == FBPH_OFS_LEVEL_VIEW
        |=> rdata_out[7:4] == FBPH_RSVD_FILL
    ) else $error("Level view upper bits not filled");

    a_latch_upper_zero: assert property ( // R11
        @(posedge ref_clk_in) disable iff (rst_in)
        rd_in && addr_in == FBPH_OFS_OUT_LATCH
        |=> rdata_out[7:4] == 4'h0
    ) else $error("Latch upper bits not zero");

    a_latch_readback: assert property ( // R10
        @(posedge ref_clk_in) disable iff (rst_in)
        wr_in && addr_in == FBPH_OFS_OUT_LATCH ##1 rd_in && addr_in == FBPH_OFS_OUT_LATCH
        |=> rdata_out[3:0] == $past(wdata_in[3:0], 2)
    ) else $error("Latch readback wrong");

    a_latch_write: assert property ( // R10
        @(posedge ref_clk_in) disable iff (rst_in)
        wr_in && addr_in == FBPH_OFS_OUT_LATCH
        |=> output_latch == $past(wdata_in[3:0])
    ) else $error("Latch write lost");

    a_latch_hold: assert property ( // R10
        @(posedge ref_clk_in) disable iff (rst_in)
        !(wr_in && addr_in == FBPH_OFS_OUT_LATCH)
        |=> $stable(output_latch)
    ) else $error("Latch changed without write");

    a_dir_write: assert property ( // R3
        @(posedge ref_clk_in) disable iff (rst_in)
        wr_in && addr_in == FBPH_OFS_DIRECTION
        |=> pin_direction == $past(wdata_in[3:0])
    ) else $error("Direction write lost");

    a_dir_hold: assert property ( // R3
        @(posedge ref_clk_in) disable iff (rst_in)
        !(wr_in && addr_in == FBPH_OFS_DIRECTION)
        |=> $stable(pin_direction)
    ) else $error("Direction changed without write");

    a_view_input: assert property ( // R12
        @(posedge ref_clk_in) disable iff (rst_in)
        rd_in && addr_in == FBPH_OFS_LEVEL_VIEW && pin_direction[0] == 1'b0
        |=> rdata_out[0] == $past(pin_in[0])
    ) else $error("Level view misses pin");

    a_view_output: assert property ( // R12
        @(posedge ref_clk_in) disable iff (rst_in)
        rd_in && addr_in == FBPH_OFS_LEVEL_VIEW && pin_direction[1] == 1'b1
        |=> rdata_out[1] == $past(output_latch[1])
    ) else $error("Level view misses latch");

    a_view_readonly: assert property ( // R13
        @(posedge ref_clk_in) disable iff (rst_in)
        wr_in && addr_in == FBPH_OFS_LEVEL_VIEW
        |=> $stable(output_latch) && $stable(pin_direction)
    ) else $error("Level view write had effect");

    a_strobe_drive: assert property ( // R4
        @(posedge ref_clk_in) disable iff (rst_in)
        bus_mode && control[FBPH_CTL_OEE] && control[FBPH_CTL_OES]
        |-> !pin_oe_n_out[3] && pin_out[3] == oe_strobe_in
    ) else $error("Strobe not driven");

    a_pin3_cs_drive: assert property ( // R5
        @(posedge ref_clk_in) disable iff (rst_in)
        bus_mode && !strobe_sel && control[FBPH_CTL_CS_LO + 3] && pin_direction[3]
        |-> !pin_oe_n_out[3] && pin_out[3] == chip_select_in[3]
    ) else $error("Pin3 select not driven");

    a_cs_input: assert property ( // R5
        @(posedge ref_clk_in) disable iff (rst_in)
        !strobe_sel && control[FBPH_CTL_CS_LO + 3] && !pin_direction[3]
        |-> pin_oe_n_out[3]
    ) else $error("Pin3 select not input");

    a_pin3_gpio: assert property ( // R6
        @(posedge ref_clk_in) disable iff (rst_in)
        !strobe_sel && !control[FBPH_CTL_CS_LO + 3]
        |-> pin_oe_n_out[3] == !pin_direction[3] && pin_out[3] == output_latch[3]
    ) else $error("Pin3 not general I/O");

    a_cs_drive: assert property ( // R7
        @(posedge ref_clk_in) disable iff (rst_in)
        bus_mode && control[FBPH_CTL_CS_LO] && pin_direction[0]
        |-> !pin_oe_n_out[0] && pin_out[0] == chip_select_in[0]
    ) else $error("Pin0 select not driven");

    a_cs_gpio_in: assert property ( // R7
        @(posedge ref_clk_in) disable iff (rst_in)
        control[FBPH_CTL_CS_LO + 1] && !pin_direction[1]
        |-> pin_oe_n_out[1]
    ) else $error("Pin1 select not input");

    a_gpio_low: assert property ( // R8
        @(posedge ref_clk_in) disable iff (rst_in)
        control[FBPH_CTL_CS_LO + 2:FBPH_CTL_CS_LO] == 3'h0
        |-> pin_oe_n_out[2:0] == ~pin_direction[2:0] && pin_out[2:0] == output_latch[2:0]
    ) else $error("Low pins not general I/O");

    a_single_gpio: assert property ( // R9
        @(posedge ref_clk_in) disable iff (rst_in)
        (mode_in == 3'h7 || mode_in == 3'h3) && !control[FBPH_CTL_EXPANSION_ENABLE]
        |-> pin_oe_n_out == ~pin_direction && pin_out == output_latch
    ) else $error("Bus function in single mode");

    a_single_no_cs: assert property ( // R9
        @(posedge ref_clk_in) disable iff (rst_in)
        !bus_mode
        |-> cs_sel == 4'h0 && !strobe_sel
    ) else $error("Select active without expansion");

    a_latch_drives: assert property ( // R10
        @(posedge ref_clk_in) disable iff (rst_in)
        !bus_mode && pin_direction[2]
        |-> !pin_oe_n_out[2] && pin_out[2] == output_latch[2]
    ) else $error("Latch not on output pin");

    c_strobe: cover property (
        @(posedge ref_clk_in) disable iff (rst_in)
        strobe_sel
    );

    c_cs_out: cover property (
        @(posedge ref_clk_in) disable iff (rst_in)
        cs_sel[1]
    );

    c_pin3_cs: cover property (
        @(posedge ref_clk_in) disable iff (rst_in)
        cs_sel[3]
    );

    c_single: cover property (
        @(posedge ref_clk_in) disable iff (rst_in)
        !bus_mode && pin_direction != 4'h0
    );

    c_view_rd: cover property (
        @(posedge ref_clk_in) disable iff (rst_in)
        rd_in && addr_in == FBPH_OFS_LEVEL_VIEW
    );
endmodule // fbph_port

`default_nettype wire

/* File: fbph_board.sv */
// Board model for the four-bit port: drives released pins, reads back driven ones.
// Assumes active-low output enables from the port.
`timescale 1ns/100ps
`default_nettype none
module fbph_board (
    input  wire logic [3:0] drive_in,
    input  wire logic [3:0] oe_n_in,
    input  wire logic [3:0] board_in,
    output logic      [3:0] level_out
);
    // Pull-ups are absent, so a released pin shows what the board puts there
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            level_out[i] = oe_n_in[i] ? board_in[i] : drive_in[i];
        end
    end
endmodule // fbph_board
`default_nettype wire

/* File: fbph_tb.sv */
// Testbench for the four-bit port: registers, pin muxing and pin readback.
// Assumes the board model and the package of the port.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import fbph_pkg::*;
    logic       ref_clk_in, rst_in, wr_in, rd_in, oe_strobe_in;
    logic [3:0] addr_in, chip_select_in, pin_in, pin_out, pin_oe_n_out, board;
    logic [7:0] wdata_in, rdata_out;
    logic [2:0] mode_in;
    int         mismatches = 0;
    int         n_checks = 0;
    fbph_port i_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .mode_in(mode_in), .oe_strobe_in(oe_strobe_in), .chip_select_in(chip_select_in),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n_out(pin_oe_n_out));
    fbph_board i_board (.drive_in(pin_out), .oe_n_in(pin_oe_n_out), .board_in(board),
        .level_out(pin_in));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
        #1;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        #1;
        chk(rdata_out, e);
    endtask
    task automatic set_pins(input logic [2:0] m, input logic [3:0] cs, input logic s);
        @(posedge ref_clk_in);
        mode_in <= m;
        chip_select_in <= cs;
        oe_strobe_in <= s;
        #1;
    endtask
    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic t_reset();
        board <= 4'ha;
        rd(FBPH_OFS_DIRECTION, 8'h00);
        rd(FBPH_OFS_OUT_LATCH, 8'h00);
        chk({4'h0, pin_oe_n_out}, 8'h0f);
        rd(FBPH_OFS_LEVEL_VIEW, 8'h0a);
        $display("test reset done");
    endtask
    task automatic t_regs();
        wr(FBPH_OFS_OUT_LATCH, 8'hff);
        rd(FBPH_OFS_OUT_LATCH, 8'h0f);
        wr(FBPH_OFS_LEVEL_VIEW, 8'h00);
        rd(FBPH_OFS_OUT_LATCH, 8'h0f);
        wr(FBPH_OFS_DIRECTION, 8'h03);
        chk({pin_oe_n_out, pin_out}, 8'hcf);
        chk({4'h0, pin_in}, 8'h0b);
        rd(FBPH_OFS_LEVEL_VIEW, 8'h0b);
        $display("test registers done");
    endtask
    task automatic t_modes();
        wr(FBPH_OFS_DIRECTION, 8'h0f);
        wr(FBPH_OFS_CONTROL, 8'h3e);
        set_pins(FBPH_MODE_SINGLE_B, 4'hd, 1'b0);
        chk({pin_oe_n_out, pin_out}, 8'h0f);
        set_pins(3'h1, 4'hd, 1'b0);
        chk({pin_oe_n_out, pin_out}, 8'h05);
        set_pins(3'h1, 4'hd, 1'b1);
        chk({pin_oe_n_out, pin_out}, 8'h0d);
        set_pins(3'h1, 4'hd, 1'b0);
        wr(FBPH_OFS_DIRECTION, 8'h00);
        chk({4'h0, pin_oe_n_out}, 8'h07);
        wr(FBPH_OFS_DIRECTION, 8'h0f);
        wr(FBPH_OFS_CONTROL, 8'h01);
        chk({pin_oe_n_out, pin_out}, 8'h0f);
        $display("test modes done");
    endtask
    task automatic t_pin3();
        set_pins(3'h1, 4'h5, 1'b0);
        wr(FBPH_OFS_DIRECTION, 8'h08);
        wr(FBPH_OFS_CONTROL, 8'h40);
        chk({pin_oe_n_out, pin_out}, 8'h77);
        wr(FBPH_OFS_DIRECTION, 8'h00);
        chk({pin_oe_n_out, pin_out}, 8'hff);
        wr(FBPH_OFS_CONTROL, 8'h00);
        wr(FBPH_OFS_DIRECTION, 8'h08);
        chk({pin_oe_n_out, pin_out}, 8'h7f);
        rd(FBPH_OFS_LEVEL_VIEW, 8'h0a);
        $display("test pin3 done");
    endtask
    task automatic t_rst2();
        @(posedge ref_clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        #1;
        chk({4'h0, pin_oe_n_out}, 8'h0f);
        rd(FBPH_OFS_OUT_LATCH, 8'h00);
        $display("test second reset done");
    endtask
    initial begin
        ref_clk_in = 1'b0;
        forever #2.5 ref_clk_in = ~ref_clk_in;
    end
    // Whole run needs well under a microsecond
    initial begin
        #20000;
        mismatches++;
        stop_test();
    end
    initial begin
        {rst_in, wr_in, rd_in, oe_strobe_in} = 4'h8;
        {addr_in, wdata_in, mode_in, board} = '0;
        chip_select_in = 4'hd;
        repeat (5) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        t_reset();
        t_regs();
        t_modes();
        t_pin3();
        t_rst2();
        stop_test();
    end
endmodule // tb
`default_nettype wire
